// ===== hw/oss_pkg.sv
// Shared constants and types for the maintenance status register bank.
// Assumes word-aligned AHB-Lite access; byte address is four times the register index.
package oss_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices (byte address = index * 4)
  localparam logic [7:0] REG_IDX_COUNT_CLEAR = 8'h44;
  localparam logic [7:0] REG_IDX_RX_COUNT = 8'h4e;
  localparam logic [7:0] REG_IDX_SHADOW = 8'h4f;
  localparam logic [7:0] REG_IDX_LOCAL_STATUS = 8'h50;

  // Value that clears the maintenance counters
  localparam logic [7:0] COUNT_CLEAR_VALUE = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Shadow register values after reset, per role
  localparam logic [7:0] SHADOW_RST_TERMINAL = 8'h07;
  localparam logic [7:0] SHADOW_RST_CENTRE = 8'h47;

  // Local status bit positions
  localparam int unsigned BIT_LINK_SPEED = 7;
  localparam int unsigned BIT_ROLE = 6;
  localparam int unsigned BIT_LOOPBACK = 5;
  localparam int unsigned BIT_LOSS_SELECT = 4;
  localparam int unsigned BIT_DIAG_FAIL = 3;
  localparam int unsigned BIT_COPPER_DOWN = 2;

  // Local status and receive count values after reset
  localparam logic LOOPBACK_RST = 1'b0;
  localparam logic LOSS_SELECT_RST = 1'b0;
  localparam logic COPPER_DOWN_RST = 1'b1;
  localparam logic [7:0] RX_COUNT_RST = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } oss_bus_e;

endpackage

// ===== hw/oss_rx_counter.sv
// Eight-bit counter of valid received maintenance packets.
// Assumes rx_valid is a one-cycle pulse per good packet and clear is a one-cycle pulse.
`timescale 1ns/1ns
module oss_rx_counter
  import oss_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Events
  input wire logic rx_valid,
  input wire logic clear,
  // Count
  output logic [7:0] count
);

  typedef struct packed {
    logic [7:0] count;
  } oss_cnt_s;

  oss_cnt_s s_reg;
  oss_cnt_s s_next;

  // Next count; a packet with a same-cycle clear leaves the count at one
  always_comb begin
    s_next = s_reg;
    if (clear) begin
      s_next.count = RX_COUNT_RST;
    end
    if (rx_valid) begin
      s_next.count = clear ? 8'h01 : s_reg.count + 8'h01;
    end
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= '{count: RX_COUNT_RST};
    end else begin
      s_reg <= s_next;
    end
  end

  assign count = s_reg.count;

endmodule

// ===== hw/oss_shadow.sv
// Shadow copy of the link partner's status register.
// Assumes partner_status is a stable level from the partner-status logic.
`timescale 1ns/1ns
module oss_shadow
  import oss_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control
  input wire logic init_load,
  input wire logic role_terminal,
  input wire logic opt_link_up,
  input wire logic hold,
  input wire logic [7:0] partner_status,
  // Shadow value
  output logic [7:0] shadow
);

  typedef struct packed {
    logic [7:0] shadow;
  } oss_shd_s;

  oss_shd_s s_reg;
  oss_shd_s s_next;

  // Role default, hold, or follow the partner
  always_comb begin
    s_next = s_reg;
    if (init_load) begin
      s_next.shadow = role_terminal ? SHADOW_RST_TERMINAL : SHADOW_RST_CENTRE;
    end else if (hold) begin
      s_next.shadow = s_reg.shadow;
    end else if (opt_link_up) begin
      s_next.shadow = partner_status;
    end
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= '{shadow: SHADOW_RST_CENTRE};
    end else begin
      s_reg <= s_next;
    end
  end

  assign shadow = s_reg.shadow;

endmodule

// ===== hw/oss_status_regs.sv
// Maintenance status register bank with an AHB-Lite slave port.
// Assumes a single AHB-Lite master, word transfers, and pins synchronous to hclk.
// Role strap is steady while the bank is out of reset.
//
// Notes on behaviour
// - Terminal role shadows partner status while link up.
// - Centre role loads shadow once link up.
// - Centre warm reset or power-down keeps shadow.
// - Retained shadow readable until link returns.
// - Role bit reads one in terminal role.
// - Loopback bit set in any loopback state.
// - Loss-report select bit, reset zero.
// - Loss select: centre writes, terminal follows pin.
// - Diag bit: terminal pin, centre software.
// - Copper down bit, reset one, centre writable.
// - Count valid received maintenance packets.
// - Writing zero to clear register clears counters.
//
// Our own choice: the AHB-Lite register port.
`timescale 1ns/1ns
module oss_status_regs
  import oss_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Role strap and resets
  input wire logic terminal_converter_role,
  input wire logic warm_reset,
  input wire logic power_down,
  // Optical link and partner
  input wire logic opt_link_up,
  input wire logic [7:0] partner_status,
  input wire logic maint_rx_valid,
  // Status sources
  input wire logic link_speed_flag,
  input wire logic centre_loop_state_a,
  input wire logic centre_loop_state_b,
  input wire logic terminal_loop_state,
  input wire logic signal_loss_select_pin,
  input wire logic diagnostic_fail_pin,
  input wire logic copper_link_down,
  // Status out
  output logic signal_loss_report_select
);

  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte address = index * 4
  //   0x110 count clear: writing 0x00 clears the count
  //   0x138 received maintenance packet count, read only
  //   0x13c partner status shadow, read only
  //   0x140 local status:
  //     [7] link speed, [6] role, [5] loopback,
  //     [4] loss report select, [3] diag fail,
  //     [2] copper link down, [1:0] zero
  // Reads of 0x110 return zero; it holds no state.
  // Writes to read-only or unmapped words are dropped,
  // and every response is OKAY.
  // Warm reset leaves the count untouched.

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    oss_bus_e st;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic [7:0] idx;
    logic addr_ok;
    logic wr;
    logic init_done;
    logic role_terminal;
    logic link_speed_flag;
    logic loopback_state_bit;
    logic signal_loss_report_select;
    logic diagnostic_fail_bit;
    logic copper_link_down_bit;
  } oss_top_s;

  oss_top_s s_reg;
  oss_top_s s_next;

  // Submodule outputs and decode nets
  logic [7:0] shadow;
  logic [7:0] rx_count;
  logic [7:0] local_status;
  logic wr_strobe;
  logic count_clear;
  logic init_load;
  logic addr_phase;
  logic sel_clear;
  logic sel_rx_count;
  logic sel_shadow;
  logic sel_local;
  logic wr_local;

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  // Address phase taken when selected and active
  // The hsize input is ignored; every access is a word
  assign addr_phase = hsel && htrans[1] && hready;

  // Write lands in the busy cycle of the data phase
  // Only aligned words inside the low kilobyte write
  assign wr_strobe = (s_reg.st == ST_BUSY) && s_reg.wr && s_reg.addr_ok;

  assign count_clear = wr_strobe && sel_clear && (hwdata[7:0] == COUNT_CLEAR_VALUE);

  // Role defaults applied once after release of reset
  assign init_load = !s_reg.init_done;

  ////////////////////////////////////////////////////////////////////////////
  // Register selects on the latched index
  // Only bits 9:2 pick a register; higher or misaligned
  // addresses are already refused through addr_ok.

  // Count clear, write only, reads zero
  assign sel_clear = (s_reg.idx == REG_IDX_COUNT_CLEAR);

  // Received packet count, read only
  assign sel_rx_count = (s_reg.idx == REG_IDX_RX_COUNT);

  // Partner status shadow, read only
  assign sel_shadow = (s_reg.idx == REG_IDX_SHADOW);

  // Local status, partly writable
  assign sel_local = (s_reg.idx == REG_IDX_LOCAL_STATUS);

  // Software write to local status
  assign wr_local = wr_strobe && sel_local;

  // Local status image
  always_comb begin
    // Bits 1:0 always read zero
    local_status = 8'h00;
    local_status[BIT_LINK_SPEED] = s_reg.link_speed_flag;
    local_status[BIT_ROLE] = s_reg.role_terminal;
    local_status[BIT_LOOPBACK] = s_reg.loopback_state_bit;
    local_status[BIT_LOSS_SELECT] = s_reg.signal_loss_report_select;
    local_status[BIT_DIAG_FAIL] = s_reg.diagnostic_fail_bit;
    local_status[BIT_COPPER_DOWN] = s_reg.copper_link_down_bit;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_next = s_reg;
    s_next.hreadyout = 1'b1;
    // Only OKAY responses are ever given
    s_next.hresp = 1'b0;

    // Bus slave: one wait state per transfer
    // Address taken at edge 1 with hreadyout high;
    // hreadyout low for the wait cycle, while write
    // data and read data land at edge 2; hreadyout
    // high again for the master's edge 3.
    // The wait is the same for reads and writes,
    // so a read right after a write sees the new value.
    case (s_reg.st)
      ST_IDLE: begin
        if (addr_phase) begin
          // Latch index, direction and alignment
          s_next.st = ST_BUSY;
          s_next.hreadyout = 1'b0;
          s_next.idx = haddr[9:2];
          s_next.addr_ok = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);
          s_next.wr = hwrite;
        end
      end
      ST_BUSY: begin
        s_next.st = ST_IDLE;
        s_next.hrdata = 32'h00000000;
        if (s_reg.addr_ok && !s_reg.wr) begin
          if (sel_rx_count) begin
            s_next.hrdata = {24'h000000, rx_count};
          end else if (sel_shadow) begin
            s_next.hrdata = {24'h000000, shadow};
          end else if (sel_local) begin
            s_next.hrdata = {24'h000000, local_status};
          end
        end
      end
      default: begin
        s_next.st = ST_IDLE;
      end
    endcase

    // Status followed every cycle
    // Speed and loopback lag their pins by one cycle
    s_next.link_speed_flag = link_speed_flag;
    s_next.loopback_state_bit = centre_loop_state_a || centre_loop_state_b || terminal_loop_state;

    // Writable local bits: role defaults after reset,
    // warm reset restores them, terminal role follows
    // the pins, centre role takes software writes.
    if (init_load) begin
      // Catch the role strap and role-dependent defaults
      s_next.init_done = 1'b1;
      s_next.role_terminal = terminal_converter_role;
      s_next.signal_loss_report_select = terminal_converter_role ? signal_loss_select_pin : LOSS_SELECT_RST;
      s_next.diagnostic_fail_bit = diagnostic_fail_pin;
      s_next.copper_link_down_bit = COPPER_DOWN_RST;
    end else if (warm_reset) begin
      // Warm reset restores the writable defaults
      // Shadow and count are left alone here
      s_next.signal_loss_report_select = s_reg.role_terminal ? signal_loss_select_pin : LOSS_SELECT_RST;
      s_next.diagnostic_fail_bit = diagnostic_fail_pin;
      s_next.copper_link_down_bit = COPPER_DOWN_RST;
    end else if (s_reg.role_terminal) begin
      s_next.signal_loss_report_select = signal_loss_select_pin;
      s_next.diagnostic_fail_bit = diagnostic_fail_pin;
      s_next.copper_link_down_bit = copper_link_down;
    end else if (wr_local) begin
      s_next.signal_loss_report_select = hwdata[BIT_LOSS_SELECT];
      s_next.diagnostic_fail_bit = hwdata[BIT_DIAG_FAIL];
      s_next.copper_link_down_bit = hwdata[BIT_COPPER_DOWN];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  // Role bits sit at centre values until the first
  // edge after release, when the role strap is caught.

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= '{
        st: ST_IDLE,
        hreadyout: 1'b1,
        hresp: 1'b0,
        hrdata: 32'h00000000,
        idx: 8'h00,
        addr_ok: 1'b0,
        wr: 1'b0,
        init_done: 1'b0,
        role_terminal: 1'b0,
        link_speed_flag: 1'b0,
        loopback_state_bit: LOOPBACK_RST,
        signal_loss_report_select: LOSS_SELECT_RST,
        diagnostic_fail_bit: 1'b0,
        copper_link_down_bit: COPPER_DOWN_RST
      };
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Submodules

  // Partner status shadow
  // Hold on warm reset or power-down keeps the last
  // partner status readable until the link returns.
  oss_shadow u_shadow (
    .hclk(hclk),
    .hresetn(hresetn),
    .init_load(init_load),
    .role_terminal(init_load ? terminal_converter_role : s_reg.role_terminal),
    .opt_link_up(opt_link_up),
    .hold(warm_reset || power_down),
    .partner_status(partner_status),
    .shadow(shadow)
  );

  // Received maintenance packet counter
  // A packet in the same cycle as a clear still counts
  oss_rx_counter u_rx_counter (
    .hclk(hclk),
    .hresetn(hresetn),
    .rx_valid(maint_rx_valid),
    .clear(count_clear),
    .count(rx_count)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from flops
  // Every output, hresp too, is a flop

  assign hrdata = s_reg.hrdata;
  assign hreadyout = s_reg.hreadyout;
  assign hresp = s_reg.hresp;
  assign signal_loss_report_select = s_reg.signal_loss_report_select;

endmodule

// ===== tb/oss_status_regs_monitor.sv
// Bus and status checks for the status bank.
// Assumes one master, word transfers, steady straps.
`timescale 1ns/1ns
module oss_status_regs_monitor (
  // Bus
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Status
  input wire logic terminal_converter_role,
  input wire logic centre_loop_state_a,
  input wire logic centre_loop_state_b,
  input wire logic terminal_loop_state
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic take, rd_loc, bad_adr;
  // Accepted address phases
  assign take = hsel && htrans[1] && hready;
  assign rd_loc = take && !hwrite && haddr == 32'h140;
  assign bad_adr = haddr[31:10] != 22'h0 || haddr[1:0] != 2'h0;
  a_resp_okay: assert property (hresp == 1'b0) else $error("response not okay");
  a_one_wait: assert property (take |=> !hreadyout ##1 hreadyout) else $error("wait count wrong");
  a_ready_idle: assert property (!take |=> hreadyout) else $error("ready low when idle");
  a_rdata_held: assert property (hreadyout |=> $stable(hrdata)) else $error("read data moved");
  a_upper_zero: assert property (take && !hwrite |-> ##2 hrdata[31:8] == 24'h0) else $error("upper bits set");
  a_unmapped_zero: assert property (take && !hwrite && bad_adr |-> ##2 hrdata == 32'h0) else $error("unmapped read");
  a_low_zero: assert property (rd_loc |-> ##2 hrdata[1:0] == 2'h0) else $error("status low bits set");
  a_role_bit: assert property (rd_loc |-> ##2 hrdata[6] == terminal_converter_role)
    else $error("role bit wrong");
  a_loop_bit: assert property (rd_loc |-> ##2 hrdata[5] ==
    $past(centre_loop_state_a | centre_loop_state_b | terminal_loop_state, 2)) else $error("loop bit wrong");
endmodule
////////////////////////////////////////////////////////////////////////////
bind oss_status_regs oss_status_regs_monitor u_mon (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hready, .hrdata, .hreadyout, .hresp, .terminal_converter_role, .centre_loop_state_a,
  .centre_loop_state_b, .terminal_loop_state);

// ===== tb/tb_oss_status_regs.sv
// Self-checking bench for the status bank.
// Drives the bus and every status pin itself.
`timescale 1ns/1ns
module tb_oss_status_regs;
  import oss_pkg::*;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp, role = 0, warm = 0, pdn = 0;
  logic link = 0, rxv = 0, spd = 0, la = 0, lb = 0, lt = 0, selp = 0, diag = 0, cdn = 0, lsel;
  logic [1:0] htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [7:0] ps = 0, p;
  logic [2:0] v;
  int error_cnt = 0, num_checks = 0, cyc = 0, n;
  always #2 hclk = ~hclk;
  oss_status_regs dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .terminal_converter_role(role), .warm_reset(warm),
    .power_down(pdn), .opt_link_up(link), .partner_status(ps), .maint_rx_valid(rxv),
    .link_speed_flag(spd), .centre_loop_state_a(la), .centre_loop_state_b(lb),
    .terminal_loop_state(lt), .signal_loss_select_pin(selp), .diagnostic_fail_pin(diag),
    .copper_link_down(cdn), .signal_loss_report_select(lsel));
  ////////////////////////////////////////////////////////////////////////////
  // Hang guard
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One AHB-Lite single transfer
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0);
    chk(rd, exp);
  endtask
  task automatic do_reset(input logic r);
    hresetn <= 1'b0;
    role <= r;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
  endtask
  // Expected local status word
  function automatic logic [31:0] loc(input logic r, input logic [2:0] b);
    return {24'h0, spd, r, la | lb | lt, b, 2'h0};
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(82242));
    diag <= 1'($urandom);
    do_reset(1'b0);
    rchk(32'h13c, {24'h0, SHADOW_RST_CENTRE});
    rchk(32'h140, loc(1'b0, {1'b0, diag, 1'b1}));
    $display("test reset done");
    n = 0;
    repeat (600) begin
      rxv <= 1'($urandom);
      @(posedge hclk);
      n += rxv;
    end
    rxv <= 1'b0;
    rchk(32'h138, {24'h0, n[7:0]});
    bus(32'h110, 1'b1, 32'h5a);
    rchk(32'h138, {24'h0, n[7:0]});
    bus(32'h110, 1'b1, 32'h0);
    rchk(32'h138, 32'h0);
    $display("test counter done");
    p = 8'($urandom);
    ps <= p;
    link <= 1'b1;
    repeat (3) @(posedge hclk);
    rchk(32'h13c, {24'h0, p});
    warm <= 1'b1;
    ps <= ~p;
    repeat (3) @(posedge hclk);
    warm <= 1'b0;
    link <= 1'b0;
    pdn <= 1'b1;
    repeat (3) @(posedge hclk);
    pdn <= 1'b0;
    rchk(32'h13c, {24'h0, p});
    link <= 1'b1;
    repeat (3) @(posedge hclk);
    rchk(32'h13c, {24'h0, ~p});
    $display("test shadow done");
    for (int i = 0; i < 8; i++) begin
      {la, lb, lt} <= 3'(i);
      spd <= 1'($urandom);
      v = 3'(i) ^ 3'h5;
      bus(32'h140, 1'b1, {27'h0, v, 2'h0});
      rchk(32'h140, loc(1'b0, v));
      chk({31'h0, lsel}, {31'h0, v[2]});
    end
    $display("test centre status done");
    link <= 1'b0;
    do_reset(1'b1);
    rchk(32'h13c, {24'h0, SHADOW_RST_TERMINAL});
    p = 8'($urandom);
    ps <= p;
    link <= 1'b1;
    repeat (3) @(posedge hclk);
    rchk(32'h13c, {24'h0, p});
    repeat (4) begin
      {selp, diag, cdn} <= 3'($urandom);
      @(posedge hclk);
      bus(32'h140, 1'b1, {27'h0, ~{selp, diag, cdn}, 2'h0});
      rchk(32'h140, loc(1'b1, {selp, diag, cdn}));
      chk({31'h0, lsel}, {31'h0, selp});
    end
    $display("test terminal done");
    bus(32'h1140, 1'b1, 32'hff);
    rchk(32'h1140, 32'h0);
    rchk(32'h110, 32'h0);
    bus(32'h138, 1'b1, 32'h33);
    rchk(32'h138, 32'h0);
    rxv <= 1'b1;
    @(posedge hclk);
    rxv <= 1'b0;
    rchk(32'h138, 32'h1);
    $display("test unmapped done");
    tally_and_finish();
  end
endmodule
